// ### src/rpt_top.sv
// Purpose: Remote control and process channel TTL logic with an APB register slave.
// Assumes: All pins pass external opto-isolators and arrive asynchronously.
// Notes:   The APB slave answers with one wait-free access phase.
// Function
// RQ1 - A falling edge on the first gauge command turns ion gauge one emission on and a rising edge turns it off.
// RQ2 - A falling edge on the second gauge command turns ion gauge two emission on and a rising edge turns it off.
// RQ3 - A falling edge on the degas command starts degassing and a rising edge stops it.
// RQ4 - While the lockout line is low, emission of both ion gauges is held off.
// RQ5 - A low keypad inhibit disables the gauge keys and a low panel inhibit disables touchscreen and keypad.
// RQ6 - A falling edge on the first Pirani shutdown turns Pirani one off and a rising edge turns it on.
// RQ7 - A falling edge on the second Pirani shutdown turns Pirani two off and a rising edge turns it on.
// RQ8 - A falling edge on the log clear line clears the data log once and a rising edge does nothing.
// RQ9 - While the remote inhibit level is high, gauge, degas and filament edges are ignored.
// RQ10 - A falling edge on either filament line selects it, and a rising edge deselects only filament two.
// RQ11 - Each edge command acts once per transition, never on a held level.
// RQ12 - Each of eight process outputs is low while its channel is active and high otherwise.
// RQ13 - Each of eight process inputs counts as asserted when the far side pulls it low.
// RQ14 - Each of eight relays closes its normally-open contact while its channel is active.
// RQ15 - Every input is synchronised and edges come from comparing each sample with the previous one.
// RQ16 - No edge is reported after reset until a first synchronised sample is held.
//
// The register addresses and the APB register port were left to the implementer.
`timescale 1ns/1ps
`include "rpt_cfg.svh"
module rpt_top #(
    parameter int CHANNELS = 8,
    parameter int AW       = 8
) (
    // Clock and reset
    input  wire logic                i_ref_clk,
    input  wire logic                i_rst_n,
    // APB slave
    input  wire logic                i_psel,
    input  wire logic                i_penable,
    input  wire logic                i_pwrite,
    input  wire logic [AW-1:0]       i_paddr,
    input  wire logic [31:0]         i_pwdata,
    output logic      [31:0]         o_prdata,
    output logic                     o_pready,
    output logic                     o_pslverr,
    // Remote control pins
    input  wire logic                i_gauge_one_emission_cmd,
    input  wire logic                i_gauge_two_emission_cmd,
    input  wire logic                i_degas_cmd,
    input  wire logic                i_emission_lockout_n,
    input  wire logic                i_gauge_keypad_inhibit_n,
    input  wire logic                i_pirani_one_shutdown_cmd,
    input  wire logic                i_pirani_two_shutdown_cmd,
    input  wire logic                i_log_clear_cmd,
    input  wire logic                i_remote_inhibit_level,
    input  wire logic                i_filament_one_select_cmd,
    input  wire logic                i_filament_two_select_cmd,
    input  wire logic                i_panel_inhibit_n,
    // Process channel pins
    input  wire rpt_pkg::rpt_chan_t  i_process_in_n,
    output rpt_pkg::rpt_chan_t       o_process_out_n,
    output rpt_pkg::rpt_chan_t       o_relay_active,
    // Instrument controls
    output logic                     o_ion_gauge_one_emission,
    output logic                     o_ion_gauge_two_emission,
    output logic                     o_degas_active,
    output logic                     o_pirani_gauge_one_on,
    output logic                     o_pirani_gauge_two_on,
    output logic                     o_filament_one_on,
    output logic                     o_filament_two_on,
    output logic                     o_gauge_keys_disabled,
    output logic                     o_panel_disabled,
    output logic                     o_log_clear,
    output rpt_pkg::rpt_chan_t       o_process_in_active
);
    import rpt_pkg::*;

    rpt_remote_t lvl;
    rpt_remote_t prev;
    rpt_remote_t fall;
    rpt_remote_t rise;
    rpt_chan_t   proc_lvl;
    logic        rem_valid;
    logic        proc_valid;
    logic        seen;
    logic        cmd_ok;
    rpt_chan_t   chan_active;
    logic        remote_enable;
    rpt_sel_e    sel;
    logic [31:0] next_rdata;
    logic        next_err;
    logic        setup;
    logic        wr_take;

    // Remote and process lines are filtered separately so each group has its own start flag.
    rpt_sync #(
        .W (12)
    ) u_remote_sync (
        .i_ref_clk (i_ref_clk),
        .i_rst_n   (i_rst_n),
        .i_async   ({i_panel_inhibit_n, i_filament_two_select_cmd, i_filament_one_select_cmd,
                     i_remote_inhibit_level, i_log_clear_cmd, i_pirani_two_shutdown_cmd,
                     i_pirani_one_shutdown_cmd, i_gauge_keypad_inhibit_n, i_emission_lockout_n,
                     i_degas_cmd, i_gauge_two_emission_cmd, i_gauge_one_emission_cmd}),
        .o_level   (lvl),
        .o_valid   (rem_valid)
    ); // see RQ15

    rpt_sync #(
        .W (CHANNELS)
    ) u_process_sync (
        .i_ref_clk (i_ref_clk),
        .i_rst_n   (i_rst_n),
        .i_async   (i_process_in_n),
        .o_level   (proc_lvl),
        .o_valid   (proc_valid)
    ); // see RQ15

    // The previous sample is only trusted once it was itself a filtered value.
    always_ff @(posedge i_ref_clk) begin
        if (!i_rst_n) begin
            prev <= '1;
            seen <= 1'b0;
        end else begin
            prev <= lvl; // see RQ15
            seen <= rem_valid; // see RQ16
        end
    end

    always_comb begin
        fall = (seen && rem_valid) ? (prev & ~lvl) : '0; // see RQ11
        rise = (seen && rem_valid) ? (~prev & lvl) : '0; // see RQ11
    end

    assign cmd_ok = !lvl[`RPT_IN_INHIBIT] && remote_enable; // see RQ9

    // Lockout clears the stored state, so emission stays off after release until a new edge.
    always_ff @(posedge i_ref_clk) begin
        if (!i_rst_n) begin
            o_ion_gauge_one_emission <= 1'b0;
            o_ion_gauge_two_emission <= 1'b0;
        end else if (seen && !lvl[`RPT_IN_LOCKOUT]) begin
            o_ion_gauge_one_emission <= 1'b0; // see RQ4
            o_ion_gauge_two_emission <= 1'b0; // see RQ4
        end else if (cmd_ok) begin
            if (fall[`RPT_IN_GAUGE_ONE]) begin
                o_ion_gauge_one_emission <= 1'b1; // see RQ1
            end else if (rise[`RPT_IN_GAUGE_ONE]) begin
                o_ion_gauge_one_emission <= 1'b0; // see RQ1
            end
            if (fall[`RPT_IN_GAUGE_TWO]) begin
                o_ion_gauge_two_emission <= 1'b1; // see RQ2
            end else if (rise[`RPT_IN_GAUGE_TWO]) begin
                o_ion_gauge_two_emission <= 1'b0; // see RQ2
            end
        end
    end

    always_ff @(posedge i_ref_clk) begin
        if (!i_rst_n) begin
            o_degas_active <= 1'b0;
        end else if (cmd_ok && fall[`RPT_IN_DEGAS]) begin
            o_degas_active <= 1'b1; // see RQ3
        end else if (cmd_ok && rise[`RPT_IN_DEGAS]) begin
            o_degas_active <= 1'b0; // see RQ3
        end
    end

    // Filament one has no rising action, so it stays selected until reset.
    always_ff @(posedge i_ref_clk) begin
        if (!i_rst_n) begin
            o_filament_one_on <= 1'b0;
            o_filament_two_on <= 1'b0;
        end else if (cmd_ok) begin
            if (fall[`RPT_IN_FIL_ONE]) begin
                o_filament_one_on <= 1'b1; // see RQ10
            end
            if (fall[`RPT_IN_FIL_TWO]) begin
                o_filament_two_on <= 1'b1; // see RQ10
            end else if (rise[`RPT_IN_FIL_TWO]) begin
                o_filament_two_on <= 1'b0; // see RQ10
            end
        end
    end

    // Pirani shutdown is not subject to the remote inhibit level.
    always_ff @(posedge i_ref_clk) begin
        if (!i_rst_n) begin
            o_pirani_gauge_one_on <= `RPT_RST_PIRANI_ON;
            o_pirani_gauge_two_on <= `RPT_RST_PIRANI_ON;
        end else begin
            if (fall[`RPT_IN_PIRANI_ONE]) begin
                o_pirani_gauge_one_on <= 1'b0; // see RQ6
            end else if (rise[`RPT_IN_PIRANI_ONE]) begin
                o_pirani_gauge_one_on <= 1'b1; // see RQ6
            end
            if (fall[`RPT_IN_PIRANI_TWO]) begin
                o_pirani_gauge_two_on <= 1'b0; // see RQ7
            end else if (rise[`RPT_IN_PIRANI_TWO]) begin
                o_pirani_gauge_two_on <= 1'b1; // see RQ7
            end
        end
    end

    always_ff @(posedge i_ref_clk) begin
        if (!i_rst_n) begin
            o_log_clear           <= 1'b0;
            o_gauge_keys_disabled <= 1'b0;
            o_panel_disabled      <= 1'b0;
        end else begin
            o_log_clear           <= fall[`RPT_IN_LOG_CLEAR]; // see RQ8
            o_gauge_keys_disabled <= seen && !lvl[`RPT_IN_KEYPAD]; // see RQ5
            o_panel_disabled      <= seen && !lvl[`RPT_IN_PANEL]; // see RQ5
        end
    end

    // Process outputs and relays follow the software channel state.
    always_ff @(posedge i_ref_clk) begin
        if (!i_rst_n) begin
            o_process_out_n     <= ~`RPT_RST_CHAN_ACTIVE;
            o_relay_active      <= `RPT_RST_CHAN_ACTIVE;
            o_process_in_active <= '0;
        end else begin
            o_process_out_n     <= ~chan_active; // see RQ12
            o_relay_active      <= chan_active; // see RQ14
            o_process_in_active <= proc_valid ? ~proc_lvl : '0; // see RQ13
        end
    end

    // APB slave: read data is latched in the setup cycle so the access phase needs no wait.
    assign setup    = i_psel && !i_penable;
    assign wr_take  = i_psel && i_penable && i_pwrite;
    assign o_pready = 1'b1;

    always_comb begin
        if (i_paddr == `RPT_OFS_CHAN_ACTIVE) begin
            sel = RPT_SEL_CHAN;
        end else if (i_paddr == `RPT_OFS_CONTROL) begin
            sel = RPT_SEL_CONTROL;
        end else if (i_paddr == `RPT_OFS_REMOTE_STATUS) begin
            sel = RPT_SEL_STATUS;
        end else if (i_paddr == `RPT_OFS_REMOTE_LEVEL) begin
            sel = RPT_SEL_LEVEL;
        end else if (i_paddr == `RPT_OFS_PROCESS_IN) begin
            sel = RPT_SEL_PROCIN;
        end else begin
            sel = RPT_SEL_NONE;
        end
    end

    always_comb begin
        next_rdata = 32'h0000_0000;
        next_err   = 1'b0;
        case (sel)
            RPT_SEL_CHAN: begin
                next_rdata[7:0] = chan_active;
            end
            RPT_SEL_CONTROL: begin
                next_rdata[0] = remote_enable;
            end
            RPT_SEL_STATUS: begin
                next_rdata[`RPT_ST_ION_ONE]    = o_ion_gauge_one_emission;
                next_rdata[`RPT_ST_ION_TWO]    = o_ion_gauge_two_emission;
                next_rdata[`RPT_ST_DEGAS]      = o_degas_active;
                next_rdata[`RPT_ST_PIRANI_ONE] = o_pirani_gauge_one_on;
                next_rdata[`RPT_ST_PIRANI_TWO] = o_pirani_gauge_two_on;
                next_rdata[`RPT_ST_FIL_ONE]    = o_filament_one_on;
                next_rdata[`RPT_ST_FIL_TWO]    = o_filament_two_on;
                next_rdata[`RPT_ST_KEYS_OFF]   = o_gauge_keys_disabled;
                next_rdata[`RPT_ST_PANEL_OFF]  = o_panel_disabled;
            end
            RPT_SEL_LEVEL: begin
                next_rdata[11:0] = lvl;
            end
            RPT_SEL_PROCIN: begin
                next_rdata[7:0] = o_process_in_active;
            end
            default: begin
                next_err = 1'b1;
            end
        endcase
    end

    always_ff @(posedge i_ref_clk) begin
        if (!i_rst_n) begin
            o_prdata  <= 32'h0000_0000;
            o_pslverr <= 1'b0;
        end else if (setup) begin
            o_prdata  <= i_pwrite ? 32'h0000_0000 : next_rdata;
            o_pslverr <= next_err || (i_pwrite && sel != RPT_SEL_CHAN && sel != RPT_SEL_CONTROL);
        end
    end

    always_ff @(posedge i_ref_clk) begin
        if (!i_rst_n) begin
            chan_active   <= `RPT_RST_CHAN_ACTIVE;
            remote_enable <= `RPT_RST_CONTROL;
        end else if (wr_take && sel == RPT_SEL_CHAN) begin
            chan_active   <= i_pwdata[7:0];
        end else if (wr_take && sel == RPT_SEL_CONTROL) begin
            remote_enable <= i_pwdata[0];
        end
    end

    a_gauge_one_on: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n) // see RQ1
        fall[`RPT_IN_GAUGE_ONE] && cmd_ok && lvl[`RPT_IN_LOCKOUT] |=> o_ion_gauge_one_emission)
        else $error("gauge one emission did not start on a falling command");

    a_gauge_two_off: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n) // see RQ2
        rise[`RPT_IN_GAUGE_TWO] && cmd_ok |=> !o_ion_gauge_two_emission)
        else $error("gauge two emission did not stop on a rising command");

    a_degas_start: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n) // see RQ3
        fall[`RPT_IN_DEGAS] && cmd_ok |=> o_degas_active)
        else $error("degas did not start on a falling command");

    a_lockout_holds: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n) // see RQ4
        seen && !lvl[`RPT_IN_LOCKOUT] |=> !o_ion_gauge_one_emission && !o_ion_gauge_two_emission)
        else $error("emission active during lockout");

    a_panel_inhibit: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n) // see RQ5
        seen && !lvl[`RPT_IN_PANEL] && !lvl[`RPT_IN_KEYPAD] |=> o_panel_disabled && o_gauge_keys_disabled)
        else $error("panel or keys not disabled by a low inhibit");

    a_pirani_off: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n) // see RQ6
        fall[`RPT_IN_PIRANI_ONE] |=> !o_pirani_gauge_one_on)
        else $error("Pirani one stayed on after a falling shutdown");

    a_log_clear_once: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n) // see RQ8
        o_log_clear |-> $past(fall[`RPT_IN_LOG_CLEAR]) && !$past(rise[`RPT_IN_LOG_CLEAR]))
        else $error("log clear pulse without a falling edge");

    a_inhibit_blocks: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n) // see RQ9
        seen && lvl[`RPT_IN_INHIBIT] |=> o_degas_active == $past(o_degas_active)
            && o_filament_two_on == $past(o_filament_two_on))
        else $error("command acted while remote inhibit was high");

    a_fil_two_off: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n) // see RQ10
        rise[`RPT_IN_FIL_TWO] && cmd_ok |=> !o_filament_two_on)
        else $error("filament two stayed on after a rising command");

    a_chan_drive: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n) // see RQ12
        wr_take && sel == RPT_SEL_CHAN |=> ##1 o_process_out_n == ~$past(i_pwdata[7:0], 2)
            && o_relay_active == $past(i_pwdata[7:0], 2))
        else $error("channel outputs or relays do not follow the channel register");

    // Checked on the outputs, so a line idling low at start-up cannot fake a command.
    a_startup_quiet: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n) // see RQ16
        !seen |=> !o_ion_gauge_one_emission && !o_ion_gauge_two_emission && !o_degas_active
            && !o_filament_one_on && !o_filament_two_on && !o_log_clear
            && o_pirani_gauge_one_on && o_pirani_gauge_two_on)
        else $error("command acted before the first sample was held");
endmodule

// ### src/rpt_cfg.svh
// Purpose: Offsets, bit positions and reset values of the remote process TTL I/O block.
// Assumes: One aligned 32-bit word per register on the APB slave.
// Notes:   Definitions only.
`ifndef RPT_CFG_SVH
`define RPT_CFG_SVH

// Register byte offsets.
`define RPT_OFS_CHAN_ACTIVE   8'h00
`define RPT_OFS_CONTROL       8'h04
`define RPT_OFS_REMOTE_STATUS 8'h08
`define RPT_OFS_REMOTE_LEVEL  8'h0c
`define RPT_OFS_PROCESS_IN    8'h10

// Reset values.
`define RPT_RST_CHAN_ACTIVE   8'h00
`define RPT_RST_CONTROL       1'h1
`define RPT_RST_PIRANI_ON     1'h1

// Remote input bit positions in the synchronised vector.
`define RPT_IN_GAUGE_ONE      0
`define RPT_IN_GAUGE_TWO      1
`define RPT_IN_DEGAS          2
`define RPT_IN_LOCKOUT        3
`define RPT_IN_KEYPAD         4
`define RPT_IN_PIRANI_ONE     5
`define RPT_IN_PIRANI_TWO     6
`define RPT_IN_LOG_CLEAR      7
`define RPT_IN_INHIBIT        8
`define RPT_IN_FIL_ONE        9
`define RPT_IN_FIL_TWO        10
`define RPT_IN_PANEL          11

// Status register bit positions.
`define RPT_ST_ION_ONE        0
`define RPT_ST_ION_TWO        1
`define RPT_ST_DEGAS          2
`define RPT_ST_PIRANI_ONE     3
`define RPT_ST_PIRANI_TWO     4
`define RPT_ST_FIL_ONE        5
`define RPT_ST_FIL_TWO        6
`define RPT_ST_KEYS_OFF       7
`define RPT_ST_PANEL_OFF      8

`endif

// ### src/rpt_pkg.sv
// Purpose: Types shared by the remote process TTL I/O block.
// Assumes: Constants live in rpt_cfg.svh.
// Notes:   Widths follow the documented line counts.
package rpt_pkg;
    typedef logic [11:0] rpt_remote_t;
    typedef logic [7:0]  rpt_chan_t;
    typedef enum logic [2:0] {
        RPT_SEL_NONE,
        RPT_SEL_CHAN,
        RPT_SEL_CONTROL,
        RPT_SEL_STATUS,
        RPT_SEL_LEVEL,
        RPT_SEL_PROCIN
    } rpt_sel_e;
endpackage

// ### src/rpt_sync.sv
// Purpose: Three-stage input synchroniser with agreement filter.
// Assumes: Inputs are asynchronous to i_ref_clk.
// Notes:   o_valid rises once the first filtered sample is held.
`timescale 1ns/1ps
module rpt_sync #(
    parameter int W = 12
) (
    // Clock and reset
    input  wire logic         i_ref_clk,
    input  wire logic         i_rst_n,
    // Asynchronous lines
    input  wire logic [W-1:0] i_async,
    // Filtered levels
    output logic      [W-1:0] o_level,
    output logic              o_valid
);
    logic [W-1:0] meta;
    logic [W-1:0] stage2;
    logic [W-1:0] stage3;
    logic [1:0]   fill;

    // The first stage feeds only the second one.
    always_ff @(posedge i_ref_clk) begin
        if (!i_rst_n) begin
            meta   <= '0;
            stage2 <= '0;
            stage3 <= '0;
        end else begin
            meta   <= i_async;
            stage2 <= meta;
            stage3 <= stage2;
        end
    end

    always_ff @(posedge i_ref_clk) begin
        if (!i_rst_n) begin
            fill <= 2'h0;
        end else if (fill != 2'h3) begin
            fill <= fill + 2'h1;
        end
    end

    // After the first load, a line changes only when the second and third stages agree, so one noisy sample is dropped.
    genvar g;
    generate
        for (g = 0; g < W; g++) begin : g_bit
            always_ff @(posedge i_ref_clk) begin
                if (!i_rst_n) begin
                    o_level[g] <= 1'b1;
                end else if (fill == 2'h3 && !o_valid) begin
                    o_level[g] <= stage3[g];
                end else if (o_valid && stage2[g] == stage3[g]) begin
                    o_level[g] <= stage3[g];
                end
            end
        end
    endgenerate

    always_ff @(posedge i_ref_clk) begin
        if (!i_rst_n) begin
            o_valid <= 1'b0;
        end else if (fill == 2'h3) begin
            o_valid <= 1'b1;
        end
    end
endmodule

// ### dv/rpt_far_model.sv
// Purpose: Model of the automation equipment that drives the remote and process lines.
// Assumes: The bench calls the tasks just after a rising clock edge.
// Notes:   Lines idle in their inactive state, so an edge command is only sent by request.
`timescale 1ns/1ps
module rpt_far_model (
    // Remote control lines, bit order as in the synchronised vector
    output rpt_pkg::rpt_remote_t o_pins,
    // Process channel lines
    output rpt_pkg::rpt_chan_t   o_proc_n
);
    import rpt_pkg::*;

    // Edge lines rest high, inhibit rests low so that commands are honoured.
    initial begin
        o_pins   = 12'heff;
        o_proc_n = 8'hff;
    end

    task automatic set_pin(input int idx, input logic val);
        o_pins[idx] <= val;
    endtask

    // A channel is asserted by pulling its line low.
    task automatic set_proc(input rpt_chan_t asserted);
        o_proc_n <= ~asserted;
    endtask
endmodule

// ### dv/tb_remote_process_ttl_io.sv
// Purpose: Self-checking bench for the remote process TTL I/O block.
// Assumes: APB answers without wait states but the bus tasks still wait for pready.
// Notes:   Pins are given eight cycles to pass the synchroniser before outputs are checked.
`timescale 1ns/1ps
`include "rpt_cfg.svh"
module tb_remote_process_ttl_io;
    import rpt_pkg::*;
    logic clk = 1'b0, rst_n = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0, prdata, rd;
    logic pready, pslverr, err, log_clr;
    rpt_remote_t pins;
    rpt_chan_t proc_n, out_n, relay, proc_act;
    logic [8:0] st, exp_st;
    int num_errors = 0, n_checks = 0, n_clr = 0;
    int idx[5] = '{0, 1, 2, 9, 10};
    int sbit[5] = '{0, 1, 2, 5, 6};

    always #2 clk = ~clk;
    always @(posedge clk) if (log_clr === 1'b1) n_clr++;

    rpt_far_model i_far (.o_pins(pins), .o_proc_n(proc_n));
    rpt_top i_dut (.i_ref_clk(clk), .i_rst_n(rst_n), .i_psel(psel), .i_penable(penable), .i_pwrite(pwrite),
        .i_paddr(paddr), .i_pwdata(pwdata), .o_prdata(prdata), .o_pready(pready), .o_pslverr(pslverr),
        .i_gauge_one_emission_cmd(pins[0]), .i_gauge_two_emission_cmd(pins[1]), .i_degas_cmd(pins[2]),
        .i_emission_lockout_n(pins[3]), .i_gauge_keypad_inhibit_n(pins[4]), .i_pirani_one_shutdown_cmd(pins[5]),
        .i_pirani_two_shutdown_cmd(pins[6]), .i_log_clear_cmd(pins[7]), .i_remote_inhibit_level(pins[8]),
        .i_filament_one_select_cmd(pins[9]), .i_filament_two_select_cmd(pins[10]), .i_panel_inhibit_n(pins[11]),
        .i_process_in_n(proc_n), .o_process_out_n(out_n), .o_relay_active(relay),
        .o_ion_gauge_one_emission(st[0]), .o_ion_gauge_two_emission(st[1]), .o_degas_active(st[2]),
        .o_pirani_gauge_one_on(st[3]), .o_pirani_gauge_two_on(st[4]), .o_filament_one_on(st[5]),
        .o_filament_two_on(st[6]), .o_gauge_keys_disabled(st[7]), .o_panel_disabled(st[8]),
        .o_log_clear(log_clr), .o_process_in_active(proc_act));

    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        n_checks++;
        if (g !== e) begin
            num_errors++;
            $display("[FAIL] %s expected %h seen %h", nm, e, g);
        end
    endtask

    // Setup cycle, then access phase held until pready is sampled high.
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] wd);
        @(posedge clk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= wd;
        @(posedge clk);
        penable <= 1'b1;
        @(posedge clk);
        while (pready !== 1'b1) @(posedge clk);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic pin(input int i, input logic v);
        @(posedge clk);
        i_far.set_pin(i, v);
        repeat (8) @(posedge clk);
    endtask

    task automatic chk_st(input string nm);
        chk({nm, " ports"}, 32'(exp_st), 32'(st));
        apb(1'b0, `RPT_OFS_REMOTE_STATUS, 32'h0);
        chk({nm, " status reg"}, 32'(exp_st), rd);
    endtask

    task automatic report_and_stop;
        $display("checks %0d mismatches %0d", n_checks, num_errors);
        if (num_errors == 0 && n_checks > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask

    initial begin
        repeat (20000) @(posedge clk);
        num_errors++;
        report_and_stop;
    end

    initial begin
        repeat (8) @(posedge clk);
        rst_n <= 1'b1;
        repeat (8) @(posedge clk);
        exp_st = 9'h018;
        chk_st("reset");
        chk("out_n reset", 32'hff, 32'(out_n));
        apb(1'b0, `RPT_OFS_CONTROL, 32'h0);
        chk("control reset", 32'h1, rd);
        apb(1'b0, 8'h14, 32'h0);
        chk("unmapped err", 32'h1, 32'(err));
        apb(1'b1, `RPT_OFS_REMOTE_STATUS, 32'hffff);
        chk("ro write err", 32'h1, 32'(err));
        apb(1'b1, `RPT_OFS_CHAN_ACTIVE, 32'ha5);
        repeat (3) @(posedge clk);
        chk("process out", 32'h5a, 32'(out_n));
        chk("relay", 32'ha5, 32'(relay));
        $display("test registers and channels done");
        // A fall turns each command on; only filament one ignores the rise.
        for (int k = 0; k < 5; k++) begin
            pin(idx[k], 1'b0);
            exp_st[sbit[k]] = 1'b1;
            chk_st("edge on");
            pin(idx[k], 1'b1);
            if (idx[k] != 9) exp_st[sbit[k]] = 1'b0;
            chk_st("edge off");
        end
        for (int k = 5; k < 7; k++) begin
            pin(k, 1'b0);
            exp_st[k - 2] = 1'b0;
            chk_st("pirani off");
            pin(k, 1'b1);
            exp_st[k - 2] = 1'b1;
            chk_st("pirani on");
        end
        $display("test edge commands done");
        pin(8, 1'b1);
        pin(0, 1'b0);
        pin(10, 1'b0);
        chk_st("inhibited");
        pin(0, 1'b1);
        pin(10, 1'b1);
        pin(8, 1'b0);
        pin(0, 1'b0);
        exp_st[0] = 1'b1;
        chk_st("gauge on");
        pin(3, 1'b0);
        exp_st[0] = 1'b0;
        chk_st("lockout");
        pin(3, 1'b1);
        pin(0, 1'b1);
        pin(4, 1'b0);
        pin(11, 1'b0);
        exp_st[8:7] = 2'b11;
        chk_st("keys panel off");
        pin(4, 1'b1);
        pin(11, 1'b1);
        exp_st[8:7] = 2'b00;
        chk_st("keys panel on");
        apb(1'b1, `RPT_OFS_CONTROL, 32'h0);
        apb(1'b0, `RPT_OFS_CONTROL, 32'h0);
        chk("control write", 32'h0, rd);
        pin(1, 1'b0);
        chk_st("remote disabled");
        pin(1, 1'b1);
        apb(1'b1, `RPT_OFS_CONTROL, 32'h1);
        pin(1, 1'b0);
        exp_st[1] = 1'b1;
        chk_st("remote enabled");
        pin(1, 1'b1);
        exp_st[1] = 1'b0;
        chk_st("remote enabled off");
        $display("test levels done");
        n_clr = 0;
        pin(7, 1'b0);
        repeat (20) @(posedge clk);
        chk("log pulses fall", 32'h1, 32'(n_clr));
        pin(7, 1'b1);
        chk("log pulses rise", 32'h1, 32'(n_clr));
        @(posedge clk);
        i_far.set_proc(8'hc3);
        repeat (8) @(posedge clk);
        chk("process in", 32'hc3, 32'(proc_act));
        apb(1'b0, `RPT_OFS_PROCESS_IN, 32'h0);
        chk("process in reg", 32'hc3, rd);
        apb(1'b0, `RPT_OFS_REMOTE_LEVEL, 32'h0);
        chk("level reg", 32'heff, rd);
        $display("test log and process inputs done");
        report_and_stop;
    end
endmodule
